// ### status_flags_pkg.sv
// Shared constants and types for the status flag bank
package status_flags_pkg;

  localparam logic [7:0] ADDR_REVISION = 8'h00;
  localparam logic [7:0] ADDR_COMMON = 8'h01;
  localparam logic [7:0] ADDR_PORT = 8'h02;

  // Common flag bit positions
  localparam int BIT_FAULT = 7;
  localparam int BIT_BAT_OV = 6;
  localparam int BIT_BAT_UV = 5;
  localparam int BIT_THERMAL = 4;
  localparam int BIT_LOW_POWER = 3;
  localparam int BIT_SHDN_EXIT = 2;
  localparam int BIT_SAFE0V = 1;
  localparam int BIT_VB_WINDOW = 0;

  // Port flag bit positions
  localparam int BIT_PORT_STATE = 5;
  localparam int BIT_PIN_STATE = 4;
  localparam int BIT_CUR_STATUS = 3;
  localparam int BIT_CONN_POWER = 2;
  localparam int BIT_CONN_OCP = 1;
  localparam int BIT_DET_ABORT = 0;

  localparam logic [7:0] COMMON_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] PORT_VALID_MASK = 8'h3f;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int FAULT_W = 4;
  localparam int PORT_STATE_W = 3;
  localparam int PIN_STATE_W = 2;
  localparam int CUR_STATUS_W = 2;

  // Status indications from the analog and port-controller sections
  typedef struct packed {
    logic [FAULT_W-1:0] fault;
    logic bat_ov;
    logic bat_uv;
    logic thermal;
    logic low_power;
    logic safe0v;
    logic vb_window;
    logic [PORT_STATE_W-1:0] port_state;
    logic [PIN_STATE_W-1:0] pin_state;
    logic [CUR_STATUS_W-1:0] cur_status;
    logic conn_power;
    logic conn_ocp;
  } status_t;

  localparam int STATUS_W = $bits(status_t);

endpackage

// ### level_sync_change.sv
// Three-stage synchroniser with agreement filter and change pulse
`timescale 1ns/10ps
`default_nettype none
module level_sync_change #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Asynchronous levels
  input wire logic [WIDTH-1:0] async_in,
  // Filtered level and per-bit change pulse
  output logic [WIDTH-1:0] stable_out,
  output logic [WIDTH-1:0] change_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;

  // First stage feeds only the second
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit counts only once two later stages agree on it
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      stable_out <= '0;
      change_out <= '0;
    end
    else
    begin
      stable_out <= (agree & s2_q) | (~agree & stable_out);
      change_out <= agree & (s2_q ^ stable_out);
    end
  end

endmodule
`default_nettype wire

// ### status_interrupt_flags.sv
// Latched status-change flag bank with revision register
`timescale 1ns/10ps
`default_nettype none
module status_interrupt_flags
  import status_flags_pkg::*;
#(
  // Arbitrary neutral value
  parameter logic [7:0] HW_REVISION = 8'h5a
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Status indications, asynchronous to the core clock
  input wire status_t status_in,
  // Single-cycle events from same-clock logic
  input wire logic wake_serial_in,
  input wire logic wake_attach_in,
  input wire logic det_abort_in,
  // Register port from the serial interface engine
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire logic [7:0] reg_wr_data_in,
  input wire logic reg_rd_en_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Flag mirrors
  output logic [7:0] common_flags_out,
  output logic [7:0] port_flags_out
);

  logic [STATUS_W-1:0] stable_vec;
  logic [STATUS_W-1:0] change_vec;
  status_t stable_s;
  status_t chg_s;
  logic [7:0] common_set;
  logic [7:0] port_set;
  logic [7:0] common_clr;
  logic [7:0] port_clr;

  // Write-one-to-clear mask for one register
  function automatic logic [7:0] clear_mask(input logic en, input logic [7:0] addr,
                                            input logic [7:0] target, input logic [7:0] data);
    clear_mask = (en && (addr == target)) ? data : 8'h00;
  endfunction

  level_sync_change #(
    .WIDTH(STATUS_W)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(status_in),
    .stable_out(stable_vec),
    .change_out(change_vec)
  );

  assign stable_s = status_t'(stable_vec);
  assign chg_s = status_t'(change_vec);

  always_comb
  begin
    common_set = 8'h00;
    common_set[BIT_FAULT] = |chg_s.fault;
    common_set[BIT_BAT_OV] = chg_s.bat_ov;
    common_set[BIT_BAT_UV] = chg_s.bat_uv;
    common_set[BIT_THERMAL] = chg_s.thermal;
    common_set[BIT_LOW_POWER] = chg_s.low_power;
    common_set[BIT_SHDN_EXIT] = wake_serial_in | wake_attach_in;
    common_set[BIT_SAFE0V] = chg_s.safe0v;
  end

  always_comb
  begin
    port_set = 8'h00;
    port_set[BIT_PORT_STATE] = |chg_s.port_state;
    port_set[BIT_PIN_STATE] = |chg_s.pin_state;
    port_set[BIT_CUR_STATUS] = |chg_s.cur_status;
    port_set[BIT_CONN_POWER] = chg_s.conn_power;
    port_set[BIT_CONN_OCP] = chg_s.conn_ocp;
    port_set[BIT_DET_ABORT] = det_abort_in;
  end

  // Revision address never matches a clear, so its writes vanish
  assign common_clr = clear_mask(reg_wr_en_in, reg_addr_in, ADDR_COMMON, reg_wr_data_in);
  assign port_clr = clear_mask(reg_wr_en_in, reg_addr_in, ADDR_PORT, reg_wr_data_in);

  // Sticky flags; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      common_flags_out <= COMMON_RESET;
    end
    else
    begin
      common_flags_out <= (common_flags_out & ~common_clr) | common_set;
      // Window bit is a live level, not sticky
      common_flags_out[BIT_VB_WINDOW] <= stable_s.vb_window;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      port_flags_out <= PORT_RESET;
    end
    else
    begin
      port_flags_out <= ((port_flags_out & ~port_clr) | port_set) & PORT_VALID_MASK;
    end
  end

  // Read returns the value before any same-cycle clear
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      rd_data_out <= READ_UNMAPPED;
      rd_valid_out <= 1'b0;
    end
    else
    begin
      rd_valid_out <= reg_rd_en_in;
      if (reg_rd_en_in)
      begin
        unique case (reg_addr_in)
          ADDR_REVISION: rd_data_out <= HW_REVISION;
          ADDR_COMMON: rd_data_out <= common_flags_out;
          ADDR_PORT: rd_data_out <= port_flags_out;
          default: rd_data_out <= READ_UNMAPPED;
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  fault_set_a: assert property (|chg_s.fault |=> common_flags_out[BIT_FAULT])
    else $error("fault change flag not set");
  bat_ov_set_a: assert property (chg_s.bat_ov |=> common_flags_out[BIT_BAT_OV])
    else $error("battery overvoltage flag not set");
  bat_uv_set_a: assert property (chg_s.bat_uv |=> common_flags_out[BIT_BAT_UV])
    else $error("battery undervoltage flag not set");
  thermal_set_a: assert property (chg_s.thermal |=> common_flags_out[BIT_THERMAL])
    else $error("thermal flag not set");
  low_power_set_a: assert property (chg_s.low_power |=> common_flags_out[BIT_LOW_POWER])
    else $error("low power flag not set");
  shdn_exit_a: assert property ((wake_serial_in || wake_attach_in) |=> common_flags_out[BIT_SHDN_EXIT])
    else $error("shutdown exit flag not set");
  vb_window_a: assert property ($changed(stable_s.vb_window) |=>
                                common_flags_out[BIT_VB_WINDOW] == $past(stable_s.vb_window))
    else $error("window flag does not follow bus voltage");
  revision_ro_a: assert property ((reg_rd_en_in && reg_addr_in == ADDR_REVISION) |=>
                                  rd_valid_out && rd_data_out == HW_REVISION)
    else $error("revision read wrong");
  port_state_a: assert property (|chg_s.port_state |=> port_flags_out[BIT_PORT_STATE])
    else $error("port state flag not set");
  conn_ocp_a: assert property (chg_s.conn_ocp |=> port_flags_out[BIT_CONN_OCP])
    else $error("overcurrent flag not set");
  det_abort_a: assert property (det_abort_in |=> port_flags_out[BIT_DET_ABORT])
    else $error("detection abort flag not set");
  flag_hold_a: assert property ((common_flags_out[BIT_FAULT] && !common_clr[BIT_FAULT]) [*2] |=>
                                common_flags_out[BIT_FAULT])
    else $error("fault flag dropped without clear");
  flag_clear_a: assert property ((port_clr[BIT_DET_ABORT] && !port_set[BIT_DET_ABORT]) |=>
                                 !port_flags_out[BIT_DET_ABORT])
    else $error("abort flag not cleared by write");

  fault_seen_c: cover property (|chg_s.fault ##1 common_flags_out[BIT_FAULT]);
  clear_seen_c: cover property (common_flags_out[BIT_FAULT] ##1 common_clr[BIT_FAULT] ##1
                                !common_flags_out[BIT_FAULT]);
  port_read_c: cover property ((reg_rd_en_in && reg_addr_in == ADDR_PORT) ##1 rd_data_out != 8'h00);
  set_clear_race_c: cover property (port_clr[BIT_DET_ABORT] && det_abort_in);

endmodule
`default_nettype wire

// ### status_interrupt_flags_tb.sv
// Self-checking testbench for the status flag bank
`timescale 1ns/10ps
`default_nettype none
module status_interrupt_flags_tb;
  import status_flags_pkg::*;
  logic core_clk_in;
  logic rst_in;
  status_t status_in;
  status_t prev;
  logic wake_serial_in, wake_attach_in, det_abort_in;
  logic [7:0] reg_addr_in, reg_wr_data_in, rd_data_out, common_flags_out, port_flags_out;
  logic reg_wr_en_in, reg_rd_en_in, rd_valid_out;
  logic [7:0] lfsr;
  logic [7:0] rdat;
  logic [15:0] e;
  int fail_count;
  int tests_run;

  status_interrupt_flags #(.HW_REVISION(8'hc3)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .status_in(status_in), .wake_serial_in(wake_serial_in), .wake_attach_in(wake_attach_in),
    .det_abort_in(det_abort_in), .reg_addr_in(reg_addr_in), .reg_wr_en_in(reg_wr_en_in),
    .reg_wr_data_in(reg_wr_data_in), .reg_rd_en_in(reg_rd_en_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .common_flags_out(common_flags_out), .port_flags_out(port_flags_out));

  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // Expected flags after a status move from a to b, starting from a cleared bank
  function automatic logic [15:0] expect_flags(status_t a, status_t b);
    return {|(a.fault ^ b.fault), a.bat_ov ^ b.bat_ov, a.bat_uv ^ b.bat_uv, a.thermal ^ b.thermal,
      a.low_power ^ b.low_power, 1'b0, a.safe0v ^ b.safe0v, b.vb_window, 2'b00,
      |(a.port_state ^ b.port_state), |(a.pin_state ^ b.pin_state), |(a.cur_status ^ b.cur_status),
      a.conn_power ^ b.conn_power, a.conn_ocp ^ b.conn_ocp, 1'b0};
  endfunction

  function automatic logic [7:0] next_lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    reg_addr_in = a;
    reg_wr_data_in = d;
    reg_wr_en_in = 1'b1;
    @(posedge core_clk_in);
    #1 reg_wr_en_in = 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic reg_read(logic [7:0] a, output logic [7:0] d);
    reg_addr_in = a;
    reg_rd_en_in = 1'b1;
    @(posedge core_clk_in);
    #1 reg_rd_en_in = 1'b0;
    check({7'h00, rd_valid_out}, 8'h01);
    d = rd_data_out;
    // Valid is a one-cycle pulse; the gap also keeps back-to-back calls apart
    @(posedge core_clk_in);
    #1;
    check({7'h00, rd_valid_out}, 8'h00);
  endtask

  // Write-one clears both banks; the window bit stays a level
  task automatic clear_all();
    reg_write(ADDR_COMMON, 8'hff);
    reg_write(ADDR_PORT, 8'hff);
    check(common_flags_out, {7'h00, prev.vb_window});
    check(port_flags_out, 8'h00);
  endtask

  task automatic step(status_t s);
    status_in = s;
    repeat (8) @(posedge core_clk_in);
    #1;
    e = expect_flags(prev, s);
    prev = s;
    check(common_flags_out, e[15:8]);
    check(port_flags_out, e[7:0]);
    reg_write(ADDR_COMMON, 8'h00);
    reg_read(ADDR_COMMON, rdat);
    check(rdat, e[15:8]);
    reg_read(ADDR_PORT, rdat);
    check(rdat, e[7:0]);
    clear_all();
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    fail_count++;
    final_report();
  end

  initial
  begin
    fail_count = 0;
    tests_run = 0;
    lfsr = 8'h52;
    rst_in = 1'b1;
    status_in = '0;
    prev = '0;
    {wake_serial_in, wake_attach_in, det_abort_in, reg_wr_en_in, reg_rd_en_in} = 5'h00;
    reg_addr_in = 8'h00;
    reg_wr_data_in = 8'h00;
    repeat (10) @(posedge core_clk_in);
    #1 rst_in = 1'b0;
    reg_read(ADDR_REVISION, rdat);
    check(rdat, 8'hc3);
    reg_write(ADDR_REVISION, 8'h3c);
    reg_read(ADDR_REVISION, rdat);
    check(rdat, 8'hc3);
    reg_read(ADDR_COMMON, rdat);
    check(rdat, 8'h00);
    reg_read(ADDR_PORT, rdat);
    check(rdat, 8'h00);
    // Unmapped address: write has no effect, read returns zero
    reg_write(8'h03, 8'hff);
    reg_read(8'h03, rdat);
    check(rdat, 8'h00);
    $display("test registers done");
    for (int i = 0; i < STATUS_W; i++)
      step(status_t'(prev ^ (STATUS_W'(1) << i)));
    $display("test single changes done");
    for (int i = 0; i < 3; i++)
    begin
      {det_abort_in, wake_attach_in, wake_serial_in} = 3'b001 << i;
      @(posedge core_clk_in);
      #1 {det_abort_in, wake_attach_in, wake_serial_in} = 3'b000;
      @(posedge core_clk_in);
      #1;
      check(common_flags_out, {5'h00, i < 2, 1'b0, prev.vb_window});
      check(port_flags_out, {7'h00, i == 2});
      clear_all();
    end
    // Abort event in the very cycle its clear is written: the set must win
    reg_addr_in = ADDR_PORT;
    reg_wr_data_in = 8'h01;
    reg_wr_en_in = 1'b1;
    det_abort_in = 1'b1;
    @(posedge core_clk_in);
    #1 {det_abort_in, reg_wr_en_in} = 2'b00;
    check(port_flags_out, 8'h01);
    @(posedge core_clk_in);
    #1;
    clear_all();
    $display("test event pulses done");
    // Multi-bit moves catch flags that watch only one bit of a field
    for (int i = 0; i < 20; i++)
    begin
      lfsr = next_lfsr(lfsr);
      step(status_t'(prev ^ {lfsr, lfsr[2:0], lfsr}));
    end
    $display("test random changes done");
    final_report();
  end
endmodule
`default_nettype wire
